// ### rtl/irqw_ctrl.sv
// interrupt, sleep wake-up and reset-status controller with ahb-lite registers
`default_nettype none
// Operation
// - eight interrupt sources feed the flag register
// - port-6 input change raises flag, outputs excluded
// - enabled pin change wakes core, vectors if enabled
// - external input ignores pulses under 8 clocks
// - external edge selectable rising or falling
// - enable instruction sets, disable clears global enable
// - enabled pending interrupt fetches from 008H
// - flags set regardless of mask, except port-6
// - request is flags AND mask AND global enable, none while asleep
// - return instruction re-enables global interrupts
// - flag register bit order as defined
// - power-on, reset pin, watchdog start reset
// - expiry and power-down flags per reset type
// - instructions and time-out update status flags
// - resets clear flag and wake registers
module irqw_ctrl #(
	parameter int FILTER_CYCLES = irqw_pkg::NOISE_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [1:0] hresp,
	output logic [31:0] hrdata,
	input wire irqw_pkg::irqw_core_cmd_t core_cmd,
	input wire irqw_pkg::irqw_src_t src_evt,
	input wire logic ext_irq_pin,
	input wire logic [7:0] port6_pins,
	input wire logic [7:0] port6_is_output,
	input wire logic reset_pin_n,
	input wire logic watchdog_timeout,
	input wire logic watchdog_enable,
	output irqw_pkg::irqw_core_out_t core_out,
	output logic irq
);
	import irqw_pkg::*;

	typedef struct packed {
		logic [7:0] pending_flag_reg;
		logic [7:0] irq_mask_register;
		logic [7:0] wake_control_register;
		logic ext_fall_edge;
		logic [7:0] port6_ref;
		logic ext_prev;
		logic [EV_W-1:0] evt_stat;
		logic [EV_W-1:0] evt_en;
		logic wr_pend;
		logic [5:0] wr_idx;
		logic [31:0] rdata;
		logic ready;
		logic [1:0] resp;
		logic irq;
		irqw_core_out_t co;
	} irqw_state_t;

	irqw_state_t s_ff;
	irqw_state_t nxt_s;
	logic ext_clean;

	// ==================================================================
	// register read mux; unmapped and write-only words read zero
	function automatic logic [31:0] reg_read(input irqw_state_t st, input logic [5:0] idx);
		logic [31:0] w;
		w = WORD_ZERO;
		case (idx)
			IDX_WAKE_CTRL: w[7:0] = st.wake_control_register;
			IDX_IRQ_FLAG: w[7:0] = st.pending_flag_reg;
			IDX_IRQ_MASK: w[7:0] = st.irq_mask_register;
			IDX_EXT_CTRL: w[0] = st.ext_fall_edge;
			IDX_CORE_STAT: begin
				w[CST_GIE] = st.co.gie;
				w[CST_SLEEP] = st.co.sleeping;
				w[CST_PWRDN] = st.co.power_down;
				w[CST_WDEXP] = st.co.wd_expiry;
			end
			IDX_EVT_STAT: w[EV_W-1:0] = st.evt_stat;
			IDX_EVT_EN: w[EV_W-1:0] = st.evt_en;
			default: w = WORD_ZERO;
		endcase
		return w;
	endfunction

	// ==================================================================
	// external interrupt input conditioning
	irqw_noise_filt #(
		.CYCLES(FILTER_CYCLES)
	) u_filt (
		.clk(clk),
		.reset(reset),
		.raw_level(ext_irq_pin),
		.clean_level(ext_clean)
	);

	// ==================================================================
	// next-state logic
	logic port6_change;
	logic ext_evt;
	logic blk_rst;
	logic wake_now;
	logic bus_take;
	logic addr_ok;
	logic [7:0] set_flags;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.co.wake = 1'b0;
		nxt_s.co.vector = IRQ_VECTOR;
		nxt_s.ready = 1'b1;
		nxt_s.resp = HRESP_OKAY;

		// only input pins take part; the reference moves with every change
		port6_change = |((port6_pins ^ s_ff.port6_ref) & ~port6_is_output);
		ext_evt = s_ff.ext_fall_edge ? (s_ff.ext_prev & ~ext_clean) : (~s_ff.ext_prev & ext_clean);
		nxt_s.ext_prev = ext_clean;
		// the core's read of port 6 refreshes the reference
		if (port6_change || core_cmd.port6_read) begin
			nxt_s.port6_ref = port6_pins;
		end

		// register write data phase
		if (s_ff.wr_pend) begin
			case (s_ff.wr_idx)
				IDX_WAKE_CTRL: nxt_s.wake_control_register = hwdata[7:0] & WAKE_WMASK;
				IDX_IRQ_FLAG: nxt_s.pending_flag_reg = hwdata[7:0];
				IDX_IRQ_MASK: nxt_s.irq_mask_register = hwdata[7:0];
				IDX_EXT_CTRL: nxt_s.ext_fall_edge = hwdata[0];
				IDX_EVT_CLR: nxt_s.evt_stat = s_ff.evt_stat & ~hwdata[EV_W-1:0];
				IDX_EVT_EN: nxt_s.evt_en = hwdata[EV_W-1:0];
				default: nxt_s.evt_en = nxt_s.evt_en;
			endcase
		end

		// address phase; zero wait states, read data registered here
		addr_ok = (haddr[31:8] == 24'h00_0000);
		bus_take = hsel && hready && htrans[1];
		nxt_s.wr_pend = bus_take && hwrite && addr_ok;
		nxt_s.wr_idx = haddr[7:2];
		nxt_s.rdata = WORD_ZERO;
		if (bus_take && !hwrite && addr_ok) begin
			nxt_s.rdata = reg_read(s_ff, haddr[7:2]);
		end

		// sources set flags after a write, so an event is never lost
		set_flags = RST_BYTE;
		set_flags[FLG_TIMER] = src_evt.timer_overflow;
		set_flags[FLG_PORT6] = port6_change && s_ff.irq_mask_register[FLG_PORT6];
		set_flags[FLG_EXT] = ext_evt;
		set_flags[FLG_CONV] = src_evt.conversion_done;
		set_flags[FLG_PWM1] = src_evt.pwm_ch1_match;
		set_flags[FLG_PWM2] = src_evt.pwm_ch2_match;
		set_flags[FLG_PWM3] = src_evt.pwm_ch3_match;
		set_flags[FLG_CMP] = src_evt.comparator_change;
		nxt_s.pending_flag_reg = nxt_s.pending_flag_reg | set_flags;

		// global enable; an enable in the same cycle as an ack wins
		if (core_cmd.global_irq_off_instr || core_cmd.irq_ack) begin
			nxt_s.co.gie = 1'b0;
		end
		if (core_cmd.global_irq_on_instr || core_cmd.return_from_irq) begin
			nxt_s.co.gie = 1'b1;
		end

		// status flags from instructions
		if (core_cmd.watchdog_clear_instr) begin
			nxt_s.co.wd_expiry = 1'b1;
			nxt_s.co.power_down = 1'b1;
		end
		if (core_cmd.sleep_instr) begin
			nxt_s.co.sleeping = 1'b1;
			nxt_s.co.wd_expiry = 1'b1;
			nxt_s.co.power_down = 1'b0;
		end

		// wake from sleep, each source gated by its wake enable
		wake_now = s_ff.co.sleeping &&
			((port6_change && s_ff.wake_control_register[WK_PORT6]) ||
			(src_evt.conversion_done && s_ff.wake_control_register[WK_CONV]) ||
			(src_evt.comparator_change && s_ff.wake_control_register[WK_CMP]));
		if (wake_now) begin
			nxt_s.co.sleeping = 1'b0;
			nxt_s.co.wake = 1'b1;
			nxt_s.co.wake_to_vector = s_ff.co.gie;
			nxt_s.co.wd_expiry = 1'b1;
			nxt_s.co.power_down = 1'b0;
			nxt_s.evt_stat[EV_WAKE] = 1'b1;
		end

		// request to the core lags state by one clock; no request in sleep
		nxt_s.co.irq_req = s_ff.co.gie && !s_ff.co.sleeping &&
			(|(s_ff.pending_flag_reg & s_ff.irq_mask_register));
		if (nxt_s.co.irq_req && !s_ff.co.irq_req) begin
			nxt_s.evt_stat[EV_IRQ] = 1'b1;
		end

		// pin and watchdog resets override the flag, mask, wake, enable, sleep and request state above
		blk_rst = !reset_pin_n || (watchdog_timeout && watchdog_enable);
		if (blk_rst) begin
			nxt_s.pending_flag_reg = RST_BYTE;
			nxt_s.wake_control_register = RST_BYTE;
			nxt_s.irq_mask_register = RST_BYTE;
			nxt_s.co.gie = 1'b0;
			nxt_s.co.sleeping = 1'b0;
			nxt_s.co.irq_req = 1'b0;
			nxt_s.co.wake = 1'b0;
			nxt_s.wr_pend = 1'b0;
			nxt_s.co.wd_expiry = s_ff.co.wd_expiry;
			nxt_s.co.power_down = s_ff.co.power_down;
			if (!reset_pin_n && s_ff.co.sleeping) begin
				nxt_s.co.wd_expiry = 1'b1;
				nxt_s.co.power_down = 1'b0;
			end
			// watchdog beats the pin: it is the later cause in the table
			if (watchdog_timeout && watchdog_enable) begin
				nxt_s.co.wd_expiry = 1'b0;
				if (s_ff.co.sleeping) begin
					nxt_s.co.power_down = 1'b0;
				end
			end
			nxt_s.evt_stat[EV_RST] = 1'b1;
		end

		nxt_s.irq = |(nxt_s.evt_stat & nxt_s.evt_en);
	end

	// ==================================================================
	// state register; power-on sets both status flags
	always_ff @(posedge clk) begin
		if (reset) begin
			s_ff <= '0;
			s_ff.ready <= 1'b1;
			s_ff.co.vector <= IRQ_VECTOR;
			s_ff.co.wd_expiry <= 1'b1;
			s_ff.co.power_down <= 1'b1;
			s_ff.evt_stat <= RST_EVT;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign hreadyout = s_ff.ready;
	assign hresp = s_ff.resp;
	assign hrdata = s_ff.rdata;
	assign core_out = s_ff.co;
	assign irq = s_ff.irq;

	// ==================================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	logic no_rst;
	assign no_rst = reset_pin_n && !(watchdog_timeout && watchdog_enable);

	sequence s_asleep_with_change;
		s_ff.co.sleeping && port6_change && s_ff.wake_control_register[WK_PORT6] && no_rst;
	endsequence

	sequence s_woken(logic to_vec);
		core_out.wake && !core_out.sleeping && (core_out.wake_to_vector == to_vec) ##1 !core_out.wake;
	endsequence

	property p_mask_and;
		(s_ff.co.gie && !s_ff.co.sleeping && |(s_ff.pending_flag_reg & s_ff.irq_mask_register) && no_rst)
			|=> core_out.irq_req && (core_out.vector == IRQ_VECTOR);
	endproperty
	a_mask_and: assert property (p_mask_and) else $error("masked request missing");

	property p_no_req_masked;
		(s_ff.pending_flag_reg & s_ff.irq_mask_register) == RST_BYTE |=> !core_out.irq_req;
	endproperty
	a_no_req_masked: assert property (p_no_req_masked) else $error("request without enabled flag");

	property p_gie_on;
		(core_cmd.global_irq_on_instr || core_cmd.return_from_irq) && no_rst |=> core_out.gie;
	endproperty
	a_gie_on: assert property (p_gie_on) else $error("global enable not set");

	property p_gie_off;
		core_cmd.global_irq_off_instr && !core_cmd.global_irq_on_instr && !core_cmd.return_from_irq
			|=> !core_out.gie;
	endproperty
	a_gie_off: assert property (p_gie_off) else $error("global enable not cleared");

	property p_timer_sticky;
		src_evt.timer_overflow && no_rst |=> s_ff.pending_flag_reg[FLG_TIMER] ##1
			(s_ff.pending_flag_reg[FLG_TIMER] || !$past(no_rst) ||
			($past(s_ff.wr_pend) && ($past(s_ff.wr_idx) == IDX_IRQ_FLAG)));
	endproperty
	a_timer_sticky: assert property (p_timer_sticky) else $error("timer flag lost");

	property p_sleep_flags;
		core_cmd.sleep_instr && !wake_now && no_rst |=> core_out.sleeping && core_out.wd_expiry && !core_out.power_down;
	endproperty
	a_sleep_flags: assert property (p_sleep_flags) else $error("sleep status wrong");

	property p_wdt_clear;
		core_cmd.watchdog_clear_instr && !core_cmd.sleep_instr && !wake_now && no_rst
			|=> core_out.wd_expiry && core_out.power_down;
	endproperty
	a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog clear status wrong");

	property p_pin_wake;
		s_asleep_with_change |=> s_woken($past(s_ff.co.gie));
	endproperty
	a_pin_wake: assert property (p_pin_wake) else $error("pin change did not wake");

	property p_rst_clear;
		!reset_pin_n |=> s_ff.pending_flag_reg == RST_BYTE && s_ff.wake_control_register == RST_BYTE && !core_out.gie;
	endproperty
	a_rst_clear: assert property (p_rst_clear) else $error("reset did not clear");

	property p_wdt_tp;
		watchdog_timeout && watchdog_enable |=> !core_out.wd_expiry &&
			(core_out.power_down == ($past(s_ff.co.power_down) && !$past(s_ff.co.sleeping)));
	endproperty
	a_wdt_tp: assert property (p_wdt_tp) else $error("watchdog status wrong");
endmodule
`default_nettype wire

// ### rtl/irqw_noise_filt.sv
// digital noise filter for the external interrupt input
`default_nettype none
module irqw_noise_filt #(
	parameter int CYCLES = irqw_pkg::NOISE_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic raw_level,
	output logic clean_level
);
	import irqw_pkg::*;

	localparam int CW = $clog2(CYCLES) + 1;
	localparam logic [CW-1:0] CNT_LAST = CW'(CYCLES - 1);
	localparam logic [CW-1:0] CNT_ZERO = '0;

	typedef struct packed {
		logic level;
		logic [CW-1:0] cnt;
	} irqw_filt_t;

	irqw_filt_t s_ff;
	irqw_filt_t nxt_s;

	// ==================================================================
	// level only follows after it differed for CYCLES clocks in a row
	always_comb begin
		nxt_s = s_ff;
		if (raw_level == s_ff.level) begin
			nxt_s.cnt = CNT_ZERO;
		end else if (s_ff.cnt == CNT_LAST) begin
			nxt_s.level = raw_level;
			nxt_s.cnt = CNT_ZERO;
		end else begin
			nxt_s.cnt = s_ff.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign clean_level = s_ff.level;

	// ==================================================================
	// checks
	property p_filter_stable;
		@(posedge clk) disable iff (reset)
		$changed(s_ff.level) |-> (s_ff.level == $past(raw_level, 1)) && (s_ff.level == $past(raw_level, CYCLES));
	endproperty
	a_filter_stable: assert property (p_filter_stable) else $error("filter passed a short pulse");
endmodule
`default_nettype wire

// ### rtl/irqw_pkg.sv
// shared constants and carrier types of the interrupt, wake and reset-status block
`default_nettype none
package irqw_pkg;
	// ==================================================================
	// register indices (byte address is four times the index)
	localparam logic [5:0] IDX_WAKE_CTRL = 6'h0e;
	localparam logic [5:0] IDX_IRQ_FLAG = 6'h0f;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h10;
	localparam logic [5:0] IDX_EXT_CTRL = 6'h11;
	localparam logic [5:0] IDX_CORE_STAT = 6'h12;
	localparam logic [5:0] IDX_EVT_STAT = 6'h13;
	localparam logic [5:0] IDX_EVT_CLR = 6'h14;
	localparam logic [5:0] IDX_EVT_EN = 6'h15;

	// ==================================================================
	// irq flag / mask bit positions
	localparam int FLG_TIMER = 0;
	localparam int FLG_PORT6 = 1;
	localparam int FLG_EXT = 2;
	localparam int FLG_CONV = 3;
	localparam int FLG_PWM1 = 4;
	localparam int FLG_PWM2 = 5;
	localparam int FLG_PWM3 = 6;
	localparam int FLG_CMP = 7;

	// wake control bit positions and writable bits
	localparam int WK_PORT6 = 1;
	localparam int WK_CMP = 2;
	localparam int WK_CONV = 3;
	localparam logic [7:0] WAKE_WMASK = 8'h0e;

	// core status bit positions
	localparam int CST_GIE = 0;
	localparam int CST_SLEEP = 1;
	localparam int CST_PWRDN = 2;
	localparam int CST_WDEXP = 3;

	// block event bits
	localparam int EV_WAKE = 0;
	localparam int EV_IRQ = 1;
	localparam int EV_RST = 2;
	localparam int EV_W = 3;

	// ==================================================================
	// reset values and fixed numbers
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [EV_W-1:0] RST_EVT = 3'h0;
	localparam logic [11:0] IRQ_VECTOR = 12'h008;
	localparam int NOISE_CYCLES = 8;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [1:0] HRESP_OKAY = 2'h0;

	// ==================================================================
	// carriers
	typedef struct packed {
		logic global_irq_on_instr;
		logic global_irq_off_instr;
		logic return_from_irq;
		logic sleep_instr;
		logic watchdog_clear_instr;
		logic irq_ack;
		logic port6_read;
	} irqw_core_cmd_t;

	typedef struct packed {
		logic timer_overflow;
		logic conversion_done;
		logic pwm_ch1_match;
		logic pwm_ch2_match;
		logic pwm_ch3_match;
		logic comparator_change;
	} irqw_src_t;

	typedef struct packed {
		logic irq_req;
		logic [11:0] vector;
		logic wake;
		logic wake_to_vector;
		logic sleeping;
		logic gie;
		logic wd_expiry;
		logic power_down;
	} irqw_core_out_t;
endpackage
`default_nettype wire

// ### sim/irqw_core_model.sv
// processor core stand-in: issues instruction pulses and takes the vector
`default_nettype none
module irqw_core_model (
	input wire logic clk,
	input wire logic reset,
	input wire irqw_pkg::irqw_core_out_t core_out,
	input wire logic op_go,
	input wire logic [2:0] op,
	input wire logic [1:0] ack_wait,
	output var irqw_pkg::irqw_core_cmd_t core_cmd
);
	timeunit 1ns;
	timeprecision 1ns;
	import irqw_pkg::*;
	logic [1:0] wait_ff;
	// ==============================
	// instruction pulses, one cycle each
	always_ff @(posedge clk) begin
		core_cmd <= '0;
		if (reset) begin
			wait_ff <= 2'h0;
		end else if (op_go) begin
			core_cmd <= irqw_core_cmd_t'(7'h40 >> op);
		end else if (core_out.irq_req && core_out.gie && !core_cmd.irq_ack) begin
			// a slow take mimics a sequencer finishing its instruction first
			if (wait_ff == ack_wait) begin
				core_cmd.irq_ack <= 1'b1;
				wait_ff <= 2'h0;
			end else begin
				wait_ff <= wait_ff + 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ### sim/tb_irqw_ctrl.sv
// self-checking bench for the interrupt, wake and reset-status controller
`default_nettype none
module tb_irqw_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	import irqw_pkg::*;
	localparam logic [2:0] op_on = 3'h0, op_off = 3'h1, op_ret = 3'h2, op_slp = 3'h3, op_wdc = 3'h4, op_p6 = 3'h6;
	logic clk, reset, hsel, hwrite, hreadyout, op_go, ext_irq_pin, reset_pin_n, watchdog_timeout, watchdog_enable, irq;
	logic [1:0] htrans, hresp, ack_wait;
	logic [2:0] op;
	logic [7:0] port6_pins;
	logic [31:0] haddr, hwdata, hrdata, rd, d;
	irqw_core_cmd_t core_cmd;
	irqw_src_t src_evt;
	irqw_core_out_t core_out;
	int fail_count, cmp_count, cycles, n, flg;
	int flg_of[6] = '{FLG_TIMER, FLG_CONV, FLG_PWM1, FLG_PWM2, FLG_PWM3, FLG_CMP};

	irqw_ctrl u_irqw_ctrl (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.core_cmd(core_cmd), .src_evt(src_evt), .ext_irq_pin(ext_irq_pin), .port6_pins(port6_pins),
		.port6_is_output(8'h0f), .reset_pin_n(reset_pin_n), .watchdog_timeout(watchdog_timeout),
		.watchdog_enable(watchdog_enable), .core_out(core_out), .irq(irq));
	irqw_core_model u_irqw_core_model (.clk(clk), .reset(reset), .core_out(core_out), .op_go(op_go), .op(op),
		.ack_wait(ack_wait), .core_cmd(core_cmd));

	// ==============================
	// checking and bus tasks
	task automatic ck(string what, logic [31:0] seen, logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(logic w, logic [5:0] idx, logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, idx, 2'h0};
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		ck("hresp", 32'(hresp), 32'h0);
	endtask
	task automatic wr(logic [5:0] idx, logic [31:0] wd);
		bus(1'b1, idx, wd);
	endtask
	task automatic rc(logic [5:0] idx, logic [31:0] exp);
		bus(1'b0, idx, 32'h0);
		ck($sformatf("reg %h", idx), rd, exp);
	endtask
	task automatic cmd(logic [2:0] o);
		@(posedge clk);
		op_go <= 1'b1;
		op <= o;
		@(posedge clk);
		op_go <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic fire(int k);
		@(posedge clk);
		src_evt <= irqw_src_t'(6'h20 >> k);
		@(posedge clk);
		src_evt <= '0;
	endtask
	task automatic wdog(logic en);
		@(posedge clk);
		watchdog_enable <= en;
		watchdog_timeout <= 1'b1;
		@(posedge clk);
		watchdog_timeout <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic rpin();
		@(posedge clk);
		reset_pin_n <= 1'b0;
		@(posedge clk);
		reset_pin_n <= 1'b1;
		repeat (2) @(posedge clk);
	endtask
	task automatic tp(logic t, logic p);
		ck("wd_expiry", 32'(core_out.wd_expiry), 32'(t));
		ck("power_down", 32'(core_out.power_down), 32'(p));
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ==============================
	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			print_verdict();
		end
	end

	// ==============================
	// scenarios
	initial begin
		void'($urandom(41));
		reset <= 1'b1;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwrite <= 1'b0;
		haddr <= 32'h0;
		hwdata <= 32'h0;
		op_go <= 1'b0;
		op <= 3'h0;
		ack_wait <= 2'h0;
		src_evt <= '0;
		ext_irq_pin <= 1'b0;
		port6_pins <= 8'($urandom);
		reset_pin_n <= 1'b1;
		watchdog_timeout <= 1'b0;
		watchdog_enable <= 1'b0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		tp(1, 1);
		for (int i = 14; i <= 21; i++) begin
			if (i != 20) begin
				rc(6'(i), (i == 18) ? 32'h0c : 32'h0);
			end
		end
		d = $urandom;
		wr(IDX_WAKE_CTRL, d);
		rc(IDX_WAKE_CTRL, d & 32'h0e);
		wr(IDX_IRQ_MASK, d);
		rc(IDX_IRQ_MASK, d & 32'hff);
		wr(6'h20, d);
		rc(6'h20, 32'h0);
		wr(IDX_CORE_STAT, d);
		rc(IDX_CORE_STAT, 32'h0c);
		wr(IDX_IRQ_MASK, 32'h0);
		wr(IDX_WAKE_CTRL, 32'h0);
		$display("test registers done");
		flg = 0;
		for (int k = 0; k < 6; k++) begin
			fire(k);
			flg |= 1 << flg_of[k];
			rc(IDX_IRQ_FLAG, 32'(flg));
		end
		rc(IDX_IRQ_FLAG, 32'hf9);
		ck("irq_req", 32'(core_out.irq_req), 32'h0);
		wr(IDX_IRQ_FLAG, 32'h0);
		$display("test sources done");
		for (int r = 0; r < 2; r++) begin
			ack_wait <= 2'(r * 3);
			wr(IDX_IRQ_MASK, 32'(1 << flg_of[r * 5]));
			cmd(op_on);
			ck("gie", 32'(core_out.gie), 32'h1);
			fire(r + 1);
			repeat (3) @(posedge clk);
			ck("irq_req", 32'(core_out.irq_req), 32'h0);
			fire(r * 5);
			for (n = 0; n < 8 && core_out.irq_req !== 1'b1; n++) begin
				@(posedge clk);
			end
			ck("irq_req", 32'(core_out.irq_req), 32'h1);
			ck("vector", 32'(core_out.vector), 32'h008);
			for (n = 0; n < 8 && core_out.gie !== 1'b0; n++) begin
				@(posedge clk);
			end
			ck("gie", 32'(core_out.gie), 32'h0);
			wr(IDX_IRQ_FLAG, 32'h0);
			cmd(op_ret);
			ck("gie", 32'(core_out.gie), 32'h1);
			ck("irq_req", 32'(core_out.irq_req), 32'h0);
			cmd(op_off);
			ck("gie", 32'(core_out.gie), 32'h0);
		end
		$display("test request done");
		wr(IDX_IRQ_MASK, 32'h0);
		ext_irq_pin <= 1'b1;
		repeat (7) @(posedge clk);
		ext_irq_pin <= 1'b0;
		repeat (12) @(posedge clk);
		rc(IDX_IRQ_FLAG, 32'h0);
		ext_irq_pin <= 1'b1;
		repeat (12) @(posedge clk);
		rc(IDX_IRQ_FLAG, 32'h4);
		wr(IDX_EXT_CTRL, 32'h1);
		wr(IDX_IRQ_FLAG, 32'h0);
		ext_irq_pin <= 1'b0;
		repeat (12) @(posedge clk);
		rc(IDX_IRQ_FLAG, 32'h4);
		wr(IDX_EXT_CTRL, 32'h0);
		wr(IDX_IRQ_FLAG, 32'h0);
		$display("test external done");
		cmd(op_p6);
		wr(IDX_IRQ_MASK, 32'h2);
		port6_pins <= port6_pins ^ 8'h0f;
		repeat (3) @(posedge clk);
		rc(IDX_IRQ_FLAG, 32'h0);
		port6_pins <= port6_pins ^ (8'h10 << ($urandom % 4));
		repeat (3) @(posedge clk);
		rc(IDX_IRQ_FLAG, 32'h2);
		wr(IDX_IRQ_FLAG, 32'h0);
		cmd(op_slp);
		ck("sleeping", 32'(core_out.sleeping), 32'h1);
		tp(1, 0);
		port6_pins <= port6_pins ^ 8'h80;
		repeat (4) @(posedge clk);
		ck("sleeping", 32'(core_out.sleeping), 32'h1);
		rpin();
		ck("sleeping", 32'(core_out.sleeping), 32'h0);
		tp(1, 0);
		for (int g = 0; g < 2; g++) begin
			wr(IDX_IRQ_MASK, 32'h2);
			wr(IDX_WAKE_CTRL, 32'h2);
			cmd(op_p6);
			if (g == 1) begin
				cmd(op_on);
			end
			cmd(op_slp);
			port6_pins <= port6_pins ^ 8'h20;
			for (n = 0; n < 8 && core_out.wake !== 1'b1; n++) begin
				@(posedge clk);
			end
			ck("wake", 32'(core_out.wake), 32'h1);
			ck("to_vector", 32'(core_out.wake_to_vector), 32'(g));
			@(posedge clk);
			ck("sleeping", 32'(core_out.sleeping), 32'h0);
			tp(1, 0);
			wr(IDX_IRQ_FLAG, 32'h0);
			cmd(op_off);
		end
		for (int c = 0; c < 2; c++) begin
			wr(IDX_WAKE_CTRL, c ? 32'h04 : 32'h08);
			cmd(op_slp);
			fire(c ? 1 : 5);
			repeat (2) @(posedge clk);
			ck("sleeping", 32'(core_out.sleeping), 32'h1);
			fire(c ? 5 : 1);
			@(posedge clk);
			ck("wake", 32'(core_out.wake), 32'h1);
			ck("sleeping", 32'(core_out.sleeping), 32'h0);
			tp(1, 0);
		end
		wr(IDX_IRQ_FLAG, 32'h0);
		$display("test wake done");
		cmd(op_wdc);
		tp(1, 1);
		fire(0);
		wr(IDX_IRQ_MASK, 32'h1);
		wdog(1'b0);
		tp(1, 1);
		rc(IDX_IRQ_FLAG, 32'h1);
		wdog(1'b1);
		tp(0, 1);
		rc(IDX_IRQ_FLAG, 32'h0);
		rc(IDX_IRQ_MASK, 32'h0);
		rpin();
		tp(0, 1);
		cmd(op_slp);
		wdog(1'b1);
		ck("sleeping", 32'(core_out.sleeping), 32'h0);
		tp(0, 0);
		$display("test watchdog done");
		rc(IDX_EVT_STAT, 32'h7);
		wr(IDX_EVT_CLR, 32'h7);
		wr(IDX_EVT_EN, 32'h4);
		rc(IDX_EVT_STAT, 32'h0);
		ck("irq", 32'(irq), 32'h0);
		rpin();
		rc(IDX_EVT_STAT, 32'h4);
		ck("irq", 32'(irq), 32'h1);
		wr(IDX_EVT_EN, 32'h3);
		repeat (2) @(posedge clk);
		ck("irq", 32'(irq), 32'h0);
		wr(IDX_EVT_EN, 32'h4);
		wr(IDX_EVT_CLR, 32'h4);
		repeat (2) @(posedge clk);
		ck("irq", 32'(irq), 32'h0);
		rc(IDX_EVT_STAT, 32'h0);
		$display("test events done");
		fire(0);
		wr(IDX_WAKE_CTRL, 32'h0e);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		repeat (2) @(posedge clk);
		tp(1, 1);
		rc(IDX_IRQ_FLAG, 32'h0);
		rc(IDX_WAKE_CTRL, 32'h0);
		$display("test power-on done");
		print_verdict();
	end
endmodule
`default_nettype wire
